// File: inc/tmx_map.vh
`ifndef TMX_MAP_VH
`define TMX_MAP_VH
// register byte offsets, one aligned word each
`define TMX_OFS_CTRL_A 8'h00
`define TMX_OFS_CTRL_B 8'h04
`define TMX_OFS_CNT_H 8'h08
`define TMX_OFS_CNT_L 8'h0C
`define TMX_OFS_CMPA_H 8'h10
`define TMX_OFS_CMPA_L 8'h14
`define TMX_OFS_CMPB_H 8'h18
`define TMX_OFS_CMPB_L 8'h1C
`define TMX_OFS_CAP_H 8'h20
`define TMX_OFS_CAP_L 8'h24
`define TMX_OFS_FLAGS 8'h28
// control field positions
`define TMX_A_FORCE_A 3
`define TMX_A_FORCE_B 2
`define TMX_B_FILTER_EN 7
`define TMX_B_EDGE_SEL 6
// flag bit positions
`define TMX_F_OVF 0
`define TMX_F_MATCH_B 1
`define TMX_F_MATCH_A 2
`define TMX_F_CAPTURE 3
// reset values
`define TMX_RST_CTRL 8'h00
`define TMX_RST_CMP 16'h0000
// fixed tops
`define TMX_TOP_MAX 16'hFFFF
`define TMX_TOP_8 16'h00FF
`define TMX_TOP_9 16'h01FF
`define TMX_TOP_10 16'h03FF
// mode kinds
`define TMX_K_NONPWM 2'h0
`define TMX_K_FAST 2'h1
`define TMX_K_PC 2'h2
`define TMX_K_PFC 2'h3
// capture filter sample count
`define TMX_FILTER_LEN 4
`endif

// File: src/tmx_timer16.v
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ns
`include "tmx_map.vh"
// Operation
// [R1] mode code is control A bits 1:0 plus control B bits 4:3
// [R2] modes 0, 4, 12: normal or clear-on-match, immediate update, flag at MAX
// [R3] modes 1-3: phase correct, tops 8/9/10 bit, update TOP, flag BOTTOM
// [R4] modes 5-7,14,15 fast PWM update BOTTOM flag TOP; mode 13 reserved
// [R5] modes 8,9 phase-frequency correct; 10,11 phase correct, capture or A top
// [R6] force strobes act only in non-PWM modes, applying compare output mode
// [R7] force strobe raises no flag and never clears the counter
// [R8] force strobe bits always read zero
// [R9] software writes zero strobes while in PWM modes
// [R10] capture filter changes only after four equal samples
// [R11] edge select bit 6: zero falling, one rising edge
// [R12] capture edge copies counter into capture value and sets capture flag
// [R13] capture input ignored when capture value is the top
// [R14] software writes zero to reserved control B bit 5
// [R15] clock select 0 stops, 1-5 choose divide 1, 8, 64, 256, 1024
// [R16] select 6/7 count falling/rising edges of the external count pin
// [R17] counter read and written as byte pair through shared high latch
// [R18] counter write blocks compare match on next timer tick
// [R19] software warned writing running counter may miss matches
// [R20] both compare values compared continuously with counter
// [R21] compare values written whole through latch, reset to zero
// [R22] match flag set on tick after equality, never by force strobe
// [R23] flags clear by writing one to their bit
// [R24] low read latches high byte; high write to latch; low write commits
// [R25] external count pin synchronised and edge detected
module tmx_timer16 (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire hsel_i,
  input wire [7:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  input wire capture_pin_i,
  input wire external_count_pin_i,
  output reg waveform_out_a_o,
  output reg waveform_out_b_o,
  output reg waveform_oe_a_o,
  output reg waveform_oe_b_o,
  output reg [3:0] flags_o
);

  reg [7:0] ctrl_a;
  reg [7:0] ctrl_b;
  reg [7:0] temp;
  reg [15:0] counter_value;
  reg [15:0] cmp_a_buf;
  reg [15:0] cmp_b_buf;
  reg [15:0] compare_value_a;
  reg [15:0] compare_value_b;
  reg [15:0] capture_value;
  reg [3:0] flags;
  reg count_up;
  reg match_block;
  reg [9:0] prescale;
  reg [2:0] ext_sync;
  reg [1:0] cap_sync;
  reg [3:0] cap_hist;
  reg cap_filt;
  reg cap_prev;
  reg dp_write;
  reg [7:0] dp_addr;

  wire [3:0] waveform_mode_code = {ctrl_b[4:3], ctrl_a[1:0]}; // [R1]
  wire [1:0] compare_output_mode_a = ctrl_a[7:6];
  wire [1:0] compare_output_mode_b = ctrl_a[5:4];
  wire [2:0] clock_source_select = ctrl_b[2:0];
  wire capture_noise_filter_en = ctrl_b[`TMX_B_FILTER_EN];
  wire capture_edge_select = ctrl_b[`TMX_B_EDGE_SEL];
  wire addr_phase = hsel_i & htrans_i[1] & hready_i;

  // kind of counting sequence per mode
  function [1:0] mode_kind;
    input [3:0] m;
    begin
      case (m)
        4'h1, 4'h2, 4'h3, 4'hA, 4'hB: mode_kind = `TMX_K_PC; // [R3] [R5]
        4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_kind = `TMX_K_FAST; // [R4]
        4'h8, 4'h9: mode_kind = `TMX_K_PFC; // [R5]
        default: mode_kind = `TMX_K_NONPWM; // [R2]
      endcase
    end
  endfunction

  // top value per mode
  function [15:0] top_value;
    input [3:0] m;
    input [15:0] cmp_a;
    input [15:0] cap;
    begin
      case (m)
        4'h1, 4'h5: top_value = `TMX_TOP_8; // [R3] [R4]
        4'h2, 4'h6: top_value = `TMX_TOP_9;
        4'h3, 4'h7: top_value = `TMX_TOP_10;
        4'h4, 4'h9, 4'hB, 4'hF: top_value = cmp_a; // [R2] [R5]
        4'h8, 4'hA, 4'hC, 4'hE: top_value = cap;
        default: top_value = `TMX_TOP_MAX;
      endcase
    end
  endfunction

  // next output level for one waveform channel
  function wave_next;
    input cur;
    input [1:0] com;
    input [1:0] kind;
    input match;
    input at_top;
    input up;
    input tog_ok;
    begin
      wave_next = cur;
      case (kind)
        `TMX_K_NONPWM:
        begin
          if (match && com == 2'h1)
            wave_next = ~cur;
          else if (match && com[1])
            wave_next = com[0];
        end
        `TMX_K_FAST:
        begin
          if (com[1] && at_top)
            wave_next = ~com[0];
          else if (com[1] && match)
            wave_next = com[0];
          else if (com == 2'h1 && match && tog_ok)
            wave_next = ~cur;
        end
        default:
        begin
          if (com[1] && match)
            wave_next = up ? com[0] : ~com[0];
          else if (com == 2'h1 && match && tog_ok)
            wave_next = ~cur;
        end
      endcase
    end
  endfunction

  reg [1:0] kind;
  reg [15:0] top;
  reg at_top;
  reg at_bottom;
  reg tick;
  reg match_a;
  reg match_b;
  reg ovf_ev;
  reg upd_ev;
  reg cap_top_mode;
  reg cap_edge;
  reg next_up;
  reg [15:0] next_cnt;
  reg [7:0] next_rdata;

  // mode decode, tick select, counting sequence, events
  always @*
  begin
    kind = mode_kind(waveform_mode_code);
    top = top_value(waveform_mode_code, compare_value_a, capture_value);
    at_top = (counter_value == top);
    at_bottom = (counter_value == 16'h0000);
    cap_top_mode = (top == capture_value) && (waveform_mode_code == 4'h8 ||
      waveform_mode_code == 4'hA || waveform_mode_code == 4'hC ||
      waveform_mode_code == 4'hE);
    case (clock_source_select) // [R15] [R16]
      3'h1: tick = 1'b1;
      3'h2: tick = (prescale[2:0] == 3'h7);
      3'h3: tick = (prescale[5:0] == 6'h3F);
      3'h4: tick = (prescale[7:0] == 8'hFF);
      3'h5: tick = (prescale == 10'h3FF);
      3'h6: tick = ext_sync[2] & ~ext_sync[1]; // [R25]
      3'h7: tick = ~ext_sync[2] & ext_sync[1];
      default: tick = 1'b0;
    endcase
    match_a = tick && !match_block && (counter_value == compare_value_a); // [R18] [R20]
    match_b = tick && !match_block && (counter_value == compare_value_b);
    next_up = count_up;
    ovf_ev = 1'b0;
    upd_ev = 1'b0;
    case (kind)
      `TMX_K_NONPWM:
      begin
        next_cnt = at_top ? 16'h0000 : counter_value + 16'h0001;
        ovf_ev = (counter_value == `TMX_TOP_MAX); // [R2]
        next_up = 1'b1;
      end
      `TMX_K_FAST:
      begin
        next_cnt = at_top ? 16'h0000 : counter_value + 16'h0001;
        ovf_ev = at_top; // [R4]
        upd_ev = at_top;
        next_up = 1'b1;
      end
      default:
      begin
        if (count_up && at_top)
          next_up = 1'b0;
        else if (!count_up && at_bottom)
          next_up = 1'b1;
        next_cnt = next_up ? counter_value + 16'h0001 : counter_value - 16'h0001;
        ovf_ev = at_bottom; // [R3] [R5]
        upd_ev = (kind == `TMX_K_PFC) ? at_bottom : at_top;
      end
    endcase
    cap_edge = (cap_filt != cap_prev) && (cap_filt == capture_edge_select) &&
      !cap_top_mode; // [R11] [R13]
    case (haddr_i)
      `TMX_OFS_CTRL_A: next_rdata = {ctrl_a[7:4], 2'h0, ctrl_a[1:0]}; // [R8]
      `TMX_OFS_CTRL_B: next_rdata = ctrl_b;
      `TMX_OFS_CNT_L: next_rdata = counter_value[7:0];
      `TMX_OFS_CMPA_H: next_rdata = compare_value_a[15:8];
      `TMX_OFS_CMPA_L: next_rdata = compare_value_a[7:0];
      `TMX_OFS_CMPB_H: next_rdata = compare_value_b[15:8];
      `TMX_OFS_CMPB_L: next_rdata = compare_value_b[7:0];
      `TMX_OFS_CNT_H, `TMX_OFS_CAP_H: next_rdata = temp; // [R24]
      `TMX_OFS_CAP_L: next_rdata = capture_value[7:0];
      `TMX_OFS_FLAGS: next_rdata = {4'h0, flags};
      default: next_rdata = 8'h00;
    endcase
  end

  // prescaler, pin synchronisers, capture filter
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prescale <= 10'h000;
      ext_sync <= 3'h0;
      cap_sync <= 2'h0;
      cap_hist <= 4'h0;
      cap_filt <= 1'b0;
      cap_prev <= 1'b0;
    end
    else
    begin
      prescale <= prescale + 10'h001;
      ext_sync <= {ext_sync[1:0], external_count_pin_i}; // [R25]
      cap_sync <= {cap_sync[0], capture_pin_i};
      cap_hist <= {cap_hist[2:0], cap_sync[1]};
      if (!capture_noise_filter_en)
        cap_filt <= cap_sync[1];
      else if (cap_hist == {`TMX_FILTER_LEN{cap_hist[0]}}) // [R10]
        cap_filt <= cap_hist[0];
      cap_prev <= cap_filt;
    end
  end

  // bus slave address phase, read data and data-phase write/address capture
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      dp_write <= addr_phase & hwrite_i;
      if (addr_phase)
        dp_addr <= haddr_i;
      if (addr_phase && !hwrite_i)
        hrdata_o <= {24'h000000, next_rdata};
    end
  end

  // registers, counter, compare units, flags and waveforms
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_a <= `TMX_RST_CTRL;
      ctrl_b <= `TMX_RST_CTRL;
      temp <= 8'h00;
      counter_value <= 16'h0000;
      cmp_a_buf <= `TMX_RST_CMP;
      cmp_b_buf <= `TMX_RST_CMP;
      compare_value_a <= `TMX_RST_CMP;
      compare_value_b <= `TMX_RST_CMP;
      capture_value <= 16'h0000;
      flags <= 4'h0;
      count_up <= 1'b1;
      match_block <= 1'b0;
      waveform_out_a_o <= 1'b0;
      waveform_out_b_o <= 1'b0;
      waveform_oe_a_o <= 1'b0;
      waveform_oe_b_o <= 1'b0;
      flags_o <= 4'h0;
    end
    else
    begin
      // timer tick: count, buffer update, waveform, flags
      if (tick)
      begin
        counter_value <= next_cnt;
        count_up <= next_up;
        match_block <= 1'b0;
        if (kind == `TMX_K_NONPWM || upd_ev)
        begin
          compare_value_a <= cmp_a_buf;
          compare_value_b <= cmp_b_buf;
        end
        waveform_out_a_o <= wave_next(waveform_out_a_o, compare_output_mode_a, kind,
          match_a, at_top, count_up, waveform_mode_code == 4'hF ||
          (kind != `TMX_K_FAST && (waveform_mode_code == 4'h9 ||
          waveform_mode_code == 4'hE)));
        waveform_out_b_o <= wave_next(waveform_out_b_o, compare_output_mode_b, kind,
          match_b, at_top, count_up, 1'b0);
      end
      // flag clear by writing one, hardware set wins
      if (dp_write && dp_addr == `TMX_OFS_FLAGS)
        flags <= flags & ~hwdata_i[3:0] | {cap_edge | (cap_top_mode & tick & at_top),
          match_a, match_b, tick & ovf_ev}; // [R23]
      else
        flags <= flags | {cap_edge | (cap_top_mode & tick & at_top),
          match_a, match_b, tick & ovf_ev}; // [R12] [R22]
      if (cap_edge)
        capture_value <= counter_value; // [R12]
      // bus data phase writes
      if (dp_write)
      begin
        case (dp_addr)
          `TMX_OFS_CTRL_A:
          begin
            ctrl_a <= {hwdata_i[7:4], 2'h0, hwdata_i[1:0]}; // [R8]
            if (mode_kind({ctrl_b[4:3], hwdata_i[1:0]}) == `TMX_K_NONPWM) // [R6] [R9]
            begin
              // forced match: output only, no flag, no clear
              if (hwdata_i[`TMX_A_FORCE_A])
                waveform_out_a_o <= wave_next(waveform_out_a_o, hwdata_i[7:6],
                  `TMX_K_NONPWM, 1'b1, 1'b0, 1'b1, 1'b1); // [R7]
              if (hwdata_i[`TMX_A_FORCE_B])
                waveform_out_b_o <= wave_next(waveform_out_b_o, hwdata_i[5:4],
                  `TMX_K_NONPWM, 1'b1, 1'b0, 1'b1, 1'b1); // [R7]
            end
          end
          `TMX_OFS_CTRL_B: ctrl_b <= {hwdata_i[7:6], 1'b0, hwdata_i[4:0]}; // [R14]
          `TMX_OFS_CNT_H, `TMX_OFS_CMPA_H, `TMX_OFS_CMPB_H: temp <= hwdata_i[7:0]; // [R24]
          `TMX_OFS_CNT_L:
          begin
            counter_value <= {temp, hwdata_i[7:0]}; // [R17]
            match_block <= 1'b1; // [R18] [R19]
          end
          `TMX_OFS_CMPA_L:
          begin
            cmp_a_buf <= {temp, hwdata_i[7:0]}; // [R21]
            if (kind == `TMX_K_NONPWM)
              compare_value_a <= {temp, hwdata_i[7:0]};
          end
          `TMX_OFS_CMPB_L:
          begin
            cmp_b_buf <= {temp, hwdata_i[7:0]}; // [R21]
            if (kind == `TMX_K_NONPWM)
              compare_value_b <= {temp, hwdata_i[7:0]};
          end
          default: ;
        endcase
      end
      // counter and capture low-byte reads latch the high byte for the next high read
      if (addr_phase && !hwrite_i && haddr_i == `TMX_OFS_CNT_L)
        temp <= counter_value[15:8]; // [R17] [R24]
      else if (addr_phase && !hwrite_i && haddr_i == `TMX_OFS_CAP_L)
        temp <= capture_value[15:8];
      waveform_oe_a_o <= (compare_output_mode_a != 2'h0);
      waveform_oe_b_o <= (compare_output_mode_b != 2'h0);
      flags_o <= flags;
    end
  end

endmodule // tmx_timer16

// File: tb/tmx_pins.sv
`timescale 1ns/1ns
module tmx_pins (
  input wire sys_clk_i,
  output logic capture_pin_o,
  output logic count_pin_o
);
  // both pins start low
  initial
  begin
    capture_pin_o = 1'b0;
    count_pin_o = 1'b0;
  end
  // hold a capture level for n clocks
  task automatic cap(input logic v, input int n);
    capture_pin_o <= v;
    repeat (n) @(posedge sys_clk_i);
  endtask
  // n slow pulses, long enough for the pin synchroniser
  task automatic pulses(input int n);
    repeat (n)
    begin
      count_pin_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      count_pin_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask
endmodule // tmx_pins

// File: tb/tmx_timer16_chk.sv
`timescale 1ns/1ns
`include "tmx_map.vh"
module tmx_timer16_chk (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire hsel_i,
  input wire [7:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  input wire [31:0] hrdata_o,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire capture_pin_i,
  input wire waveform_oe_a_o,
  input wire [3:0] flags_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire ap = hsel_i && htrans_i[1] && hready_i;
  wire rd = ap && !hwrite_i;
  reg [3:0] wf;
  reg wa;
  reg wb;
  reg [2:0] cs;
  reg [1:0] ca;
  reg [3:0] st;
  reg [3:0] ps;
  reg pin_q;
  // shadows of control writes, stop time and pin quiet time
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wf <= 4'h0;
      wa <= 1'b0;
      wb <= 1'b0;
      cs <= 3'h0;
      ca <= 2'h0;
      st <= 4'h0;
      ps <= 4'h0;
      pin_q <= 1'b0;
    end
    else
    begin
      wf <= {wf[2:0], ap && hwrite_i && haddr_i == `TMX_OFS_FLAGS};
      wa <= ap && hwrite_i && haddr_i == `TMX_OFS_CTRL_A;
      wb <= ap && hwrite_i && haddr_i == `TMX_OFS_CTRL_B;
      if (wa)
        ca <= hwdata_i[7:6];
      if (wb)
        cs <= hwdata_i[2:0];
      st <= (cs != 3'h0 || (wb && hwdata_i[2:0] != 3'h0)) ? 4'h0 : (st == 4'hF ? st : st + 4'h1);
      pin_q <= capture_pin_i;
      ps <= (capture_pin_i != pin_q) ? 4'h0 : (ps == 4'hF ? ps : ps + 4'h1);
    end
  end
  a_strobe_read_zero: assert property (rd && haddr_i == `TMX_OFS_CTRL_A |=> hrdata_o[3:2] == 2'h0)
    else $error("strobe bits read back nonzero");
  a_rsvd_read_zero: assert property (rd && haddr_i == `TMX_OFS_CTRL_B |=> !hrdata_o[5])
    else $error("reserved control bit read back set");
  a_upper_bytes_zero: assert property (rd |=> hrdata_o[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready and okay");
  a_flag_sticky: assert property (($past(flags_o) & ~flags_o) != 4'h0 |-> |wf[3:1])
    else $error("flag dropped without a clearing write");
  a_oe_follows_mode: assert property (wa |-> ##[2:3] (waveform_oe_a_o == (ca != 2'h0)))
    else $error("output enable does not follow compare output mode");
  a_stopped_quiet: assert property (st >= 4'h8 |-> (flags_o[2:0] & ~$past(flags_o[2:0])) == 3'h0)
    else $error("timer flag rose while the counter is stopped");
  a_capture_needs_edge: assert property (st >= 4'h8 && ps >= 4'hC |-> !$rose(flags_o[3]))
    else $error("capture flag rose without a pin edge");
  c_cap_read: cover property (rd && haddr_i == `TMX_OFS_CAP_L);
  c_cap_flag: cover property ($rose(flags_o[3]));
  c_match_flag: cover property ($rose(flags_o[2]));
  c_oe_on: cover property ($rose(waveform_oe_a_o));
endmodule // tmx_timer16_chk
bind tmx_timer16 tmx_timer16_chk i_tmx_timer16_chk (.*);

// File: tb/tmx_timer16_tb_top.sv
`timescale 1ns/1ns
`include "tmx_map.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tmx_timer16_tb_top;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] hwdata_i = 32'h0;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, cap_pin, cnt_pin, out_a, out_b, oe_a, oe_b;
  wire [3:0] flags_o;
  int error_cnt = 0, checks_done = 0, v, n;
  logic [7:0] rq;
  logic [15:0] cv;
  logic out_m;
  logic [1:0] bm = 2'h0;
  logic [1:0] seq [$] = '{2'h2, 2'h1, 2'h1, 2'h3, 2'h1};
  tmx_timer16 i_tmx_timer16 (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .capture_pin_i(cap_pin),
    .external_count_pin_i(cnt_pin), .waveform_out_a_o(out_a), .waveform_out_b_o(out_b),
    .waveform_oe_a_o(oe_a), .waveform_oe_b_o(oe_b), .flags_o(flags_o));
  tmx_pins i_tmx_pins (.sys_clk_i(sys_clk_i), .capture_pin_o(cap_pin), .count_pin_o(cnt_pin));
  // 20 MHz clock
  initial
    forever #25 sys_clk_i = ~sys_clk_i;
  // one single bus transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    rq = hrdata_o[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string s, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(s, e, rq)
  endtask
  // pairs: high byte first on write, low byte first on read
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[15:8]);
    wr(a + 8'h04, d[7:0]);
  endtask
  task automatic rd16(input string s, input logic [7:0] a, input logic [15:0] e);
    rd(s, a + 8'h04, e[7:0]);
    rd(s, a, e[15:8]);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #1000000;
    error_cnt++;
    wrap_up;
  end
  // main sequence
  initial
  begin
    v = $urandom(81196);
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd16("cmp_a", `TMX_OFS_CMPA_H, `TMX_RST_CMP);
    rd16("cmp_b", `TMX_OFS_CMPB_H, `TMX_RST_CMP);
    wr(8'h2C, 8'hFF);
    rd("unmapped", 8'h2C, 8'h00);
    repeat (4)
    begin
      v = $urandom;
      if (v[3:2] != 2'h0) v[1:0] = 2'h0;
      if (bm == 2'h2) v[3:2] = 2'h0;
      wr(`TMX_OFS_CTRL_A, v[7:0]);
      rd("ctrl_a", `TMX_OFS_CTRL_A, v[7:0] & 8'hF3);
      v = $urandom & 8'hC7;
      wr(`TMX_OFS_CTRL_B, v[7:0]);
      bm = v[4:3];
      rd("ctrl_b", `TMX_OFS_CTRL_B, v[7:0]);
    end
    wr(`TMX_OFS_CTRL_B, 8'h00);
    wr(`TMX_OFS_CTRL_A, 8'h00);
    wr(`TMX_OFS_FLAGS, 8'h0F);
    v = $urandom;
    wr16(`TMX_OFS_CMPA_H, v[15:0]);
    rd16("cmp_a", `TMX_OFS_CMPA_H, v[15:0]);
    wr(`TMX_OFS_CMPA_H, v[31:24]);
    wr(`TMX_OFS_CMPB_L, v[23:16]);
    rd16("cmp_b", `TMX_OFS_CMPB_H, v[31:16]);
    cv = 16'($urandom);
    wr16(`TMX_OFS_CNT_H, cv);
    rd16("counter", `TMX_OFS_CNT_H, cv);
    // forced matches in clear-on-match mode with a stopped counter
    wr(`TMX_OFS_CTRL_B, 8'h08);
    foreach (seq[i])
    begin
      wr(`TMX_OFS_CTRL_A, {seq[i], seq[i], 4'hC});
      out_m = (seq[i] == 2'h1) ? !out_m : seq[i][0];
      repeat (2) @(posedge sys_clk_i);
      `CHK("wave_a", out_m, out_a)
      `CHK("wave_b", out_m, out_b)
      `CHK("oe_a", 1'b1, oe_a)
      `CHK("oe_b", 1'b1, oe_b)
    end
    rd("flags", `TMX_OFS_FLAGS, 8'h00);
    rd16("counter", `TMX_OFS_CNT_H, cv);
    // match on channel a only, then clear it
    wr(`TMX_OFS_CTRL_A, 8'h00);
    wr(`TMX_OFS_CTRL_B, 8'h00);
    wr16(`TMX_OFS_CNT_H, 16'h0000);
    wr16(`TMX_OFS_CMPA_H, 16'h0005);
    wr16(`TMX_OFS_CMPB_H, 16'h0100);
    wr(`TMX_OFS_CTRL_B, 8'h01);
    repeat (20) @(posedge sys_clk_i);
    wr(`TMX_OFS_CTRL_B, 8'h00);
    rd("flags", `TMX_OFS_FLAGS, 8'h04);
    wr(`TMX_OFS_FLAGS, 8'h04);
    rd("flags", `TMX_OFS_FLAGS, 8'h00);
    // counter written to the compare value while running
    wr(`TMX_OFS_CTRL_B, 8'h01);
    wr16(`TMX_OFS_CNT_H, 16'h0005);
    repeat (4) @(posedge sys_clk_i);
    wr(`TMX_OFS_CTRL_B, 8'h00);
    rd("flags", `TMX_OFS_FLAGS, 8'h00);
    // external count pin on falling then rising edges
    for (int c = 6; c < 8; c++)
    begin
      wr16(`TMX_OFS_CNT_H, 16'h0000);
      wr(`TMX_OFS_CTRL_B, c[7:0]);
      n = $urandom % 5 + 1;
      i_tmx_pins.pulses(n);
      repeat (6) @(posedge sys_clk_i);
      wr(`TMX_OFS_CTRL_B, 8'h00);
      rd16("counter", `TMX_OFS_CNT_H, n[15:0]);
    end
    // filtered capture, both edge selections
    for (int e = 0; e < 2; e++)
    begin
      i_tmx_pins.cap(!e, 12);
      wr(`TMX_OFS_CTRL_B, {1'b1, e[0], 6'h00});
      wr(`TMX_OFS_FLAGS, 8'h0F);
      cv = 16'($urandom);
      wr16(`TMX_OFS_CNT_H, cv);
      i_tmx_pins.cap(e[0], 2);
      i_tmx_pins.cap(!e, 12);
      rd("flags", `TMX_OFS_FLAGS, 8'h00);
      i_tmx_pins.cap(e[0], 12);
      rd("flags", `TMX_OFS_FLAGS, 8'h08);
      `CHK("flags_o", 4'h8, flags_o)
      rd16("capture", `TMX_OFS_CAP_H, cv);
      wr(`TMX_OFS_FLAGS, 8'h08);
      i_tmx_pins.cap(!e, 12);
      rd("flags", `TMX_OFS_FLAGS, 8'h00);
    end
    // capture value as top disconnects the pin
    wr(`TMX_OFS_CTRL_B, 8'h58);
    i_tmx_pins.cap(1'b1, 12);
    rd("flags", `TMX_OFS_FLAGS, 8'h00);
    wrap_up;
  end
endmodule // tmx_timer16_tb_top
